// >>> src/fpc_checker.sv
`timescale 1ns/100ps
module fpc_checker #(
    parameter logic [7:0]  MIN_PRM_LEN   = 8'h07,
    parameter logic [7:0]  MAX_PRM_LEN   = 8'hF4,
    parameter logic [7:0]  EQUI_BLK_LEN  = 8'h1C,
    parameter logic [7:0]  S2S_VERSION   = 8'h01,
    parameter logic [15:0] FILT_MAX_LEN  = 16'h0080
) (
    // Clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_rst,
    // Register port
    input  wire logic [7:0]   i_reg_addr,
    input  wire logic [31:0]  i_reg_wdata,
    input  wire logic         i_reg_wr,
    input  wire logic         i_reg_rd,
    output logic [31:0]       o_reg_rdata,
    // Decoded parameterizing frame
    input  wire logic         i_frame_valid,
    input  wire logic [31:0]  i_frame_sig,
    input  wire logic [7:0]   i_prm_len,
    input  wire logic         i_unknown_id,
    input  wire logic [7:0]   i_status1,
    input  wire logic [7:0]   i_status3,
    input  wire logic         i_iso_present,
    input  wire logic [7:0]   i_equi_len,
    input  wire logic [15:0]  i_tbase_dp,
    input  wire logic [15:0]  i_tdp,
    input  wire logic [7:0]   i_tmapc,
    input  wire logic [15:0]  i_tbase_io,
    input  wire logic [15:0]  i_input_latch_instant,
    input  wire logic [15:0]  i_output_apply_instant,
    input  wire logic [15:0]  i_tdx,
    input  wire logic [15:0]  i_tpllw,
    input  wire logic         i_s2s_present,
    input  wire logic [7:0]   i_s2s_version,
    input  wire logic [3:0]   i_s2s_ext_links,
    input  wire logic [3:0]   i_s2s_int_links,
    input  wire logic [7:0]   i_s2s_max_access,
    input  wire logic [15:0]  i_s2s_addr_len_or,
    input  wire logic [15:0]  i_s2s_filter_len,
    // Link events
    input  wire logic         i_bus_lost,
    input  wire logic         i_gc_tick,
    input  wire logic         i_cw2_strobe,
    input  wire logic [15:0]  i_control_word_two,
    // Result
    output logic              o_frame_done,
    output logic              o_frame_accept,
    output logic              o_frame_reject,
    output logic [7:0]        o_reason,
    output logic              o_data_exchange,
    output logic              o_sync_lost
);
    import fpc_pkg::*;

    // ****************************************
    // Field checks
    // ****************************************
    logic [NCHK-1:0] fail;
    logic [4:0]      ctrl;
    logic [7:0]      maxlen;
    logic [31:0]     acc_sig;
    logic [7:0]      acc_tmapc;
    logic            acc_iso;
    fpc_dx_e         dx_state;
    fpc_dx_e         next_dx_state;
    logic [15:0]     rej_cnt;
    logic [3:0]      sol_prev;
    logic            sol_seen;
    logic [7:0]      sol_cnt;

    wire        iso = i_iso_present;
    wire        s2s = i_s2s_present;
    wire [1:0]  oms = ctrl[CTRL_OMS_MSB:CTRL_OMS_LSB];
    wire [16:0] tdx_to = {1'b0, i_tdx} + TDX_TO_MARGIN_US;
    wire [16:0] tdx_tdp = {1'b0, i_tdx} + TDX_TDP_MARGIN_US;

    assign fail[CK_LEN]  = (i_prm_len < MIN_PRM_LEN) || (i_prm_len > MAX_PRM_LEN);      // see R2
    assign fail[CK_EQUI] = iso && (i_equi_len != EQUI_BLK_LEN);                          // see R3
    assign fail[CK_ID]   = i_unknown_id;                                                 // see R4
    assign fail[CK_TBDP] = iso && (i_tbase_dp != TBASE_US);                              // see R5
    assign fail[CK_TDP]  = iso && ((i_tdp < TDP_MIN_US) || (i_tdp > TDP_MAX_US));        // see R6
    assign fail[CK_MAPC] = iso && ((i_tmapc == 8'h00) || (i_tmapc > MAPC_MAX));          // see R7
    assign fail[CK_TBIO] = iso && (i_tbase_io != TBASE_US);                              // see R8
    assign fail[CK_LATCH] = iso && (i_input_latch_instant > i_tdp);                      // see R9
    assign fail[CK_APPLY] = iso && (i_output_apply_instant > i_tdp);                     // see R9
    assign fail[CK_CHG]  = (dx_state == DX_ON) && (i_frame_sig != acc_sig);              // see R10
    assign fail[CK_OMS]  = iso && (oms == OMS_NONE);                                     // see R11
    assign fail[CK_REQ]  = i_status3[4] && !iso;                                         // see R12
    assign fail[CK_FLG]  = iso && !(i_status1[6] && i_status3[4] && i_status3[3]);       // see R13
    assign fail[CK_TDX]  = iso && ((tdx_to > {1'b0, i_output_apply_instant})
                                   || (tdx_tdp > {1'b0, i_tdp}));                        // see R14
    assign fail[CK_PLLW] = iso && (i_tpllw > PLLW_MAX_NS);                               // see R15
    assign fail[CK_ALGN] = s2s && i_s2s_addr_len_or[0];                                  // see R16
    assign fail[CK_LNKS] = s2s && ((i_s2s_ext_links > S2S_EXT_MAX)
                                   || (i_s2s_int_links > S2S_INT_MAX));                  // see R17
    assign fail[CK_ACC]  = s2s && (i_s2s_max_access > S2S_ACC_MAX);                      // see R18
    assign fail[CK_VER]  = s2s && (i_s2s_version != S2S_VERSION);                        // see R19
    assign fail[CK_FILT] = s2s && (i_s2s_filter_len > FILT_MAX_LEN);                     // see R20
    assign fail[CK_MAXL] = i_prm_len > maxlen;                                           // see R21
    assign fail[CK_S2S]  = s2s && !ctrl[CTRL_S2S_CAP];                                   // see R22

    // Lowest index is evaluated last and wins
    function automatic logic [7:0] first_code(input logic [NCHK-1:0] f);
        logic [7:0] c;
        c = 8'h00;
        for (int k = NCHK - 1; k >= 0; k--)
        begin
            if (f[k])
            begin
                c = FPC_CODES[k];
            end
        end
        return c;
    endfunction : first_code

    wire [7:0] code = first_code(fail);                                                  // see R23
    wire       take_ok = i_frame_valid && (fail == '0);
    wire       take_bad = i_frame_valid && (fail != '0);

    // ****************************************
    // Register decode
    // ****************************************
    wire hit_ctrl = i_reg_addr == ADDR_CTRL;
    wire hit_maxlen = i_reg_addr == ADDR_MAXLEN;
    wire hit_status = i_reg_addr == ADDR_STATUS;
    wire hit_reason = i_reg_addr == ADDR_REASON;
    wire hit_rejcnt = i_reg_addr == ADDR_REJCNT;
    wire leave_req = i_reg_wr && hit_ctrl && i_reg_wdata[CTRL_LEAVE];
    wire lost_clr = i_reg_wr && hit_status && i_reg_wdata[ST_LOST];
    logic       reject_sticky;
    wire [31:0] status_word = {29'h0, o_sync_lost, reject_sticky, o_data_exchange};
    wire [31:0] rd_mux = hit_ctrl   ? {27'h0, ctrl[4:4], 1'b0, ctrl[2:0]} :
                         hit_maxlen ? {24'h0, maxlen} :
                         hit_status ? status_word :
                         hit_reason ? {24'h0, o_reason} :
                         hit_rejcnt ? {16'h0, rej_cnt} : 32'h0000_0000;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl <= CTRL_RST;
            maxlen <= MAXLEN_RST;
            o_reg_rdata <= 32'h0000_0000;
        end
        else
        begin
            if (i_reg_wr && hit_ctrl)
            begin
                ctrl <= {i_reg_wdata[CTRL_SOL_EN], 1'b0, i_reg_wdata[CTRL_S2S_CAP:CTRL_OMS_LSB]};
            end
            if (i_reg_wr && hit_maxlen)
            begin
                maxlen <= i_reg_wdata[7:0];
            end
            o_reg_rdata <= i_reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // ****************************************
    // Cyclic exchange state
    // ****************************************
    always_comb
    begin
        case (dx_state)
            DX_OFF:
            begin
                next_dx_state = (take_ok && !i_bus_lost) ? DX_ON : DX_OFF;               // see R1
            end
            DX_ON:
            begin
                next_dx_state = (i_bus_lost || leave_req) ? DX_OFF : DX_ON;
            end
            default:
            begin
                next_dx_state = DX_OFF;
            end
        endcase
    end

    assign o_data_exchange = dx_state == DX_ON;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            dx_state <= DX_OFF;
        end
        else
        begin
            dx_state <= next_dx_state;
        end
    end

    // ****************************************
    // Frame verdict
    // ****************************************
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_frame_done <= 1'b0;
            o_frame_accept <= 1'b0;
            o_frame_reject <= 1'b0;
            reject_sticky <= 1'b0;
            o_reason <= 8'h00;
            rej_cnt <= 16'h0000;
            acc_sig <= 32'h0000_0000;
            acc_tmapc <= 8'h00;
            acc_iso <= 1'b0;
        end
        else
        begin
            o_frame_done <= i_frame_valid;
            o_frame_accept <= take_ok;
            o_frame_reject <= take_bad;                                                  // see R1
            if (i_frame_valid)
            begin
                o_reason <= code;                                                        // see R23
                reject_sticky <= take_bad;
            end
            if (take_bad)
            begin
                rej_cnt <= rej_cnt + 16'h0001;
            end
            if (take_ok)
            begin
                acc_sig <= i_frame_sig;
                acc_tmapc <= i_tmapc;
                acc_iso <= i_iso_present;
            end
        end
    end

    // ****************************************
    // Sign-of-life supervision
    // ****************************************
    wire [3:0] sol_now = i_control_word_two[SOL_MSB:SOL_LSB];
    wire       sol_step = i_cw2_strobe && (sol_now != sol_prev);
    wire       sol_armed = o_data_exchange && acc_iso && ctrl[CTRL_SOL_EN];
    wire       sol_bad = sol_step && sol_seen && sol_armed && (sol_cnt != acc_tmapc);

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sol_prev <= 4'h0;
            sol_seen <= 1'b0;
            sol_cnt <= 8'h00;
            o_sync_lost <= 1'b0;
        end
        else
        begin
            if (i_cw2_strobe)
            begin
                sol_prev <= sol_now;
            end
            if (!sol_armed)
            begin
                sol_seen <= 1'b0;
            end
            else if (sol_step)
            begin
                sol_seen <= 1'b1;
            end
            if (sol_step)
            begin
                sol_cnt <= 8'h00;
            end
            else if (i_gc_tick && (sol_cnt != 8'hFF))
            begin
                sol_cnt <= sol_cnt + 8'h01;
            end
            if (sol_bad)
            begin
                o_sync_lost <= 1'b1;                                                     // see R24
            end
            else if (lost_clr)
            begin
                o_sync_lost <= 1'b0;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    no_start_a: assert property (take_bad && !o_data_exchange |=> !o_data_exchange && o_frame_reject) // see R1
        else $error("rejected frame started exchange");
    len_code_a: assert property (i_frame_valid && fail[CK_LEN] |=> o_reason == 8'h08 && o_frame_reject) // see R2
        else $error("bad length not coded 8");
    tbase_code_a: assert property (i_frame_valid && fail[CK_TBDP:CK_LEN] == 4'b1000 |=> o_reason == 8'h0B) // see R5
        else $error("bad time base not coded 11");
    tdp_range_a: assert property (i_frame_valid && iso && i_tdp == 16'h7D01 && fail[3:0] == 4'h0 |=> o_reason == 8'h0C) // see R6
        else $error("cycle above range not coded 12");
    change_code_a: assert property (o_data_exchange && i_frame_valid && i_frame_sig != acc_sig
                                    && fail[8:0] == 9'h000 |=> o_reason == 8'h11) // see R10
        else $error("changed frame not coded 17");
    req_flag_a: assert property (i_frame_valid && i_status3[4] && !iso && fail[10:0] == 11'h000
                                 |=> o_reason == 8'h13 && !o_frame_accept) // see R12
        else $error("request without block not coded 19");
    order_high_a: assert property (i_frame_valid && fail[CK_MAXL] && fail[CK_S2S] && fail[19:0] == 20'h0_0000
                                   |=> o_reason == 8'h1F) // see R23
        else $error("wrong first failing code");
    accept_clean_a: assert property (o_frame_accept |-> o_reason == 8'h00 && $past(fail) == '0) // see R1
        else $error("accepted frame with failing check");
    sol_lost_a: assert property ($rose(o_sync_lost) |-> $past(i_cw2_strobe) && $past(sol_armed)) // see R24
        else $error("sync loss without sign-of-life step");
    done_pair_a: assert property (i_frame_valid |=> o_frame_done && (o_frame_accept != o_frame_reject))
        else $error("verdict not exactly one");

    accept_c: cover property (take_ok ##1 o_data_exchange);
    reject_c: cover property (take_bad && !o_data_exchange);
    change_c: cover property (o_data_exchange && i_frame_valid && fail[CK_CHG]);
    lost_c: cover property ($rose(o_sync_lost));

endmodule : fpc_checker

// >>> src/fpc_pkg.sv
//
// Contract
// R1: Failed check rejects frame, no cyclic exchange (a frame rejected while exchange runs leaves it running)
// R2: Illegal telegram length gives code 8
// R3: Illegal equidistant block length gives 9
// R4: Unknown block identifier gives code 10
// R5: Bus time base not 125 us: 11
// R6: Bus cycle outside 1..32 ms: 12
// R7: Application cycle outside 1..14 periods: 13
// R8: IO time base not 125 us: 14
// R9: Latch 15, apply 16 beyond cycle period
// R10: Changed frame during exchange gives 17
// R11: Isochronous without suitable option module: 18
// R12: Request flag without isochronous block: 19
// R13: Isochronous block, header flag missing: 20
// R14: Exchange duration too long gives 21
// R15: Synchronisation window above 1 us: 22
// R16: Misaligned slave link access gives 23
// R17: More than 3+1 links gives 24
// R18: More than 8 accesses gives 25
// R19: Unknown slave block version gives 26
// R20: Filter table too long gives 27
// R21: Frame above option module maximum: 31
// R22: Slave links unsupported by firmware: 32
// R23: Report first failing code, fixed order
// R24: Sign-of-life off schedule flags lost sync
package fpc_pkg;

    // ****************************************
    // Check order and reason codes
    // ****************************************
    localparam int NCHK = 22;
    localparam logic [7:0] FPC_CODES [0:NCHK-1] = '{
        8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12,
        8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1F, 8'h20};
    localparam int CK_LEN = 0;
    localparam int CK_EQUI = 1;
    localparam int CK_ID = 2;
    localparam int CK_TBDP = 3;
    localparam int CK_TDP = 4;
    localparam int CK_MAPC = 5;
    localparam int CK_TBIO = 6;
    localparam int CK_LATCH = 7;
    localparam int CK_APPLY = 8;
    localparam int CK_CHG = 9;
    localparam int CK_OMS = 10;
    localparam int CK_REQ = 11;
    localparam int CK_FLG = 12;
    localparam int CK_TDX = 13;
    localparam int CK_PLLW = 14;
    localparam int CK_ALGN = 15;
    localparam int CK_LNKS = 16;
    localparam int CK_ACC = 17;
    localparam int CK_VER = 18;
    localparam int CK_FILT = 19;
    localparam int CK_MAXL = 20;
    localparam int CK_S2S = 21;

    // ****************************************
    // Limits for values carried by the frame (us, window in ns), link and access limits, sign-of-life bits
    // ****************************************
    localparam logic [15:0] TBASE_US = 16'h007D;
    localparam logic [15:0] TDP_MIN_US = 16'h03E8;
    localparam logic [15:0] TDP_MAX_US = 16'h7D00;
    localparam logic [7:0]  MAPC_MAX = 8'h0E;
    localparam logic [16:0] TDX_TO_MARGIN_US = 17'h0_007D;
    localparam logic [16:0] TDX_TDP_MARGIN_US = 17'h0_00FA;
    localparam logic [15:0] PLLW_MAX_NS = 16'h03E8;
    localparam logic [3:0]  S2S_EXT_MAX = 4'h3;
    localparam logic [3:0]  S2S_INT_MAX = 4'h1;
    localparam logic [7:0]  S2S_ACC_MAX = 8'h08;
    localparam int          SOL_LSB = 12;
    localparam int          SOL_MSB = 15;

    // ****************************************
    // Register map and fields
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MAXLEN = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_REASON = 8'h0C;
    localparam logic [7:0] ADDR_REJCNT = 8'h10;
    localparam int CTRL_OMS_LSB = 0;
    localparam int CTRL_OMS_MSB = 1;
    localparam int CTRL_S2S_CAP = 2;
    localparam int CTRL_LEAVE = 3;
    localparam int CTRL_SOL_EN = 4;
    localparam int ST_DX = 0;
    localparam int ST_REJ = 1;
    localparam int ST_LOST = 2;
    localparam logic [1:0] OMS_NONE = 2'h0;
    localparam logic [4:0] CTRL_RST = 5'h10;
    localparam logic [7:0] MAXLEN_RST = 8'hF4;

    typedef enum logic [1:0] {
        DX_OFF = 2'b00,
        DX_ON  = 2'b01
    } fpc_dx_e;

endpackage : fpc_pkg

// >>> verification/fpc_master_model.sv
`timescale 1ns/100ps
module fpc_master_model
    import fpc_tb_pkg::*;
(
    // Clock
    input  wire logic              i_core_clk,
    // Frame towards the device
    output logic                   o_frame_valid,
    output fpc_tb_pkg::fpc_frame_s o_frm
);
    import fpc_tb_pkg::*;

    // ****************************************
    // Well-formed isochronous frame
    // ****************************************
    function automatic fpc_frame_s good(input logic [15:0] tdp, input logic [31:0] sig);
        fpc_frame_s f;
        f = '{sig, 8'h14, 1'b0, 8'h40, 8'h18, 1'b1, 8'h1C,
              16'h007D,
              tdp,
              8'h02,
              16'h007D,
              16'h01F4, 16'h03E8, 16'h00C8, 16'h03E8,
              1'b1, 8'h01, 4'h3, 4'h1, 8'h08, 16'h0010, 16'h0080};
        return f;
    endfunction : good

    // ****************************************
    // One broken field, chosen by index
    // ****************************************
    function automatic fpc_frame_s brk(input fpc_frame_s fi, input int k);
        fpc_frame_s f;
        f = fi;
        case (k)
            0:  f.prm_len = 8'h06;
            1:  f.equi_len = 8'h1B;
            2:  f.unknown_id = 1'b1;
            3:  f.tbase_dp = 16'h007C;
            4:  f.tdp = 16'h03E7;
            5:  f.tmapc = 8'h0F;
            6:  f.tbase_io = 16'h007E;
            7:  f.latch = f.tdp + 16'h0001;
            8:  f.apply = f.tdp + 16'h0001;
            11: f.iso = 1'b0;
            12: f.status1 = 8'h00;
            13: f.tdx = f.apply - 16'h007C;
            14: f.pllw = 16'h03E9;
            15: f.alo = 16'h0011;
            16: f.ext = 4'h4;
            17: f.acc = 8'h09;
            18: f.ver = 8'h02;
            19: f.filt = 16'h0081;
            20: f.tdp = 16'h7D01;
            21: f.tmapc = 8'h00;
            default: ;
        endcase
        return f;
    endfunction : brk

    initial
    begin
        o_frame_valid = 1'b0;
        o_frm = '0;
    end

    // Fields are inverted once the frame cycle is over
    task automatic send(input int k1, input int k2, input logic [15:0] tdp, input logic [31:0] sig);
        @(posedge i_core_clk);
        o_frame_valid <= 1'b1;
        o_frm <= brk(brk(good(tdp, sig), k1), k2);
        @(posedge i_core_clk);
        o_frame_valid <= 1'b0;
        o_frm <= ~o_frm;
    endtask : send

endmodule : fpc_master_model

// >>> verification/fpc_tb_pkg.sv
package fpc_tb_pkg;

    // ****************************************
    // Decoded frame as the master hands it over
    // ****************************************
    typedef struct packed {
        logic [31:0] sig;
        logic [7:0]  prm_len;
        logic        unknown_id;
        logic [7:0]  status1;
        logic [7:0]  status3;
        logic        iso;
        logic [7:0]  equi_len;
        logic [15:0] tbase_dp;
        logic [15:0] tdp;
        logic [7:0]  tmapc;
        logic [15:0] tbase_io;
        logic [15:0] latch;
        logic [15:0] apply;
        logic [15:0] tdx;
        logic [15:0] pllw;
        logic        s2s;
        logic [7:0]  ver;
        logic [3:0]  ext;
        logic [3:0]  intl;
        logic [7:0]  acc;
        logic [15:0] alo;
        logic [15:0] filt;
    } fpc_frame_s;

    localparam int F_NONE = 31;

endpackage : fpc_tb_pkg

// >>> verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import fpc_pkg::*;
    import fpc_tb_pkg::*;

    typedef struct packed {
        logic        is_rd;
        logic [31:0] val;
    } fpc_exp_s;

    localparam logic [7:0] CODE [0:21] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10,
        8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h0C, 8'h0D};

    logic        core_clk, rst, wr_s, rd_s, rd_seen, frame_valid, bus_lost, gc_tick, cw2_strobe;
    logic [7:0]  reg_addr, reason;
    logic [31:0] wdata, rdata, sig;
    logic [15:0] cw2, tdp;
    logic        done, acc, rej, dx, sync_lost;
    fpc_frame_s  frm;
    fpc_exp_s    exp_q [$];
    int          errors, check_count, cycles, nrej, seed;

    fpc_master_model i_master (.i_core_clk(core_clk), .o_frame_valid(frame_valid), .o_frm(frm));

    fpc_checker i_dut (
        .i_core_clk(core_clk), .i_rst(rst), .i_reg_addr(reg_addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata), .i_frame_valid(frame_valid),
        .i_frame_sig(frm.sig), .i_prm_len(frm.prm_len), .i_unknown_id(frm.unknown_id),
        .i_status1(frm.status1), .i_status3(frm.status3), .i_iso_present(frm.iso),
        .i_equi_len(frm.equi_len), .i_tbase_dp(frm.tbase_dp), .i_tdp(frm.tdp), .i_tmapc(frm.tmapc),
        .i_tbase_io(frm.tbase_io), .i_input_latch_instant(frm.latch), .i_output_apply_instant(frm.apply),
        .i_tdx(frm.tdx), .i_tpllw(frm.pllw), .i_s2s_present(frm.s2s), .i_s2s_version(frm.ver),
        .i_s2s_ext_links(frm.ext), .i_s2s_int_links(frm.intl), .i_s2s_max_access(frm.acc),
        .i_s2s_addr_len_or(frm.alo), .i_s2s_filter_len(frm.filt), .i_bus_lost(bus_lost),
        .i_gc_tick(gc_tick), .i_cw2_strobe(cw2_strobe), .i_control_word_two(cw2),
        .o_frame_done(done), .o_frame_accept(acc), .o_frame_reject(rej), .o_reason(reason),
        .o_data_exchange(dx), .o_sync_lost(sync_lost));

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    task automatic pop_cmp(input logic is_rd, input logic [31:0] got);
        fpc_exp_s e;
        if (exp_q.size() == 0)
            check("result without note", 32'h0000_0000, 32'h0000_0001);
        else
        begin
            e = exp_q.pop_front();
            check("result kind", {31'h0, e.is_rd}, {31'h0, is_rd});
            check(is_rd ? "read data" : "frame verdict", e.val, got);
        end
    endtask : pop_cmp

    always @(posedge core_clk)
    begin
        if (rd_seen)
            pop_cmp(1'b1, rdata);
        if (done === 1'b1)
            pop_cmp(1'b0, {21'h0, acc, rej, dx, reason});
        rd_seen <= rd_s;
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            end_of_test();
        end
    end

    // ****************************************
    // Drivers
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge core_clk);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back('{1'b1, exp});
        @(posedge core_clk);
        reg_addr <= a;
        rd_s <= 1'b1;
        @(posedge core_clk);
        rd_s <= 1'b0;
    endtask : rd

    task automatic frame(input int k1, input int k2, input logic [31:0] s, input logic [15:0] t,
                         input logic [7:0] code, input logic x);
        exp_q.push_back('{1'b0, {21'h0, code == 8'h00, code != 8'h00, x, code}});
        if (code != 8'h00)
            nrej++;
        i_master.send(k1, k2, t, s);
    endtask : frame

    task automatic pulse_tick();
        @(posedge core_clk);
        gc_tick <= 1'b1;
        @(posedge core_clk);
        gc_tick <= 1'b0;
    endtask : pulse_tick

    task automatic step(input logic [3:0] v);
        @(posedge core_clk);
        cw2 <= {v, 12'h000};
        cw2_strobe <= 1'b1;
        @(posedge core_clk);
        cw2_strobe <= 1'b0;
    endtask : step

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        {wr_s, rd_s, rd_seen, bus_lost, gc_tick, cw2_strobe} = '0;
        {reg_addr, wdata, cw2} = '0;
        {errors, check_count, cycles, nrej} = '0;
        seed = 32'h0000_DFE2;
        rst = 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(ADDR_CTRL, 32'h0000_0010);
        rd(ADDR_MAXLEN, 32'h0000_00F4);
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h14, 32'h0000_0000);
        rd(ADDR_STATUS, 32'h0000_0000);
        tdp = 16'(32'h0000_07D0 + ({$random(seed)} % 32'h0000_7531));
        sig = $random(seed);
        wr(ADDR_CTRL, 32'h0000_0017);
        for (int k = 0; k < 22; k++)
        begin
            if (k == 9 || k == 10)
                continue;
            frame(k, F_NONE, sig, tdp, CODE[k], '0);
        end
        for (int k = 0; k < 8; k++)
            frame(k, k + 12, sig, tdp, CODE[k], 1'b0);
        wr(ADDR_CTRL, 32'h0000_0014);
        frame(F_NONE, F_NONE, sig, tdp, 8'h12, 1'b0);
        wr(ADDR_CTRL, 32'h0000_0013);
        frame(F_NONE, F_NONE, sig, tdp, 8'h20, 1'b0);
        wr(ADDR_MAXLEN, 32'h0000_0013);
        frame(F_NONE, F_NONE, sig, tdp, 8'h1F, 1'b0);
        wr(ADDR_CTRL, 32'h0000_0017);
        frame(F_NONE, F_NONE, sig, tdp, 8'h1F, 1'b0);
        wr(ADDR_MAXLEN, 32'h0000_00F4);
        rd(ADDR_REJCNT, 32'(nrej));
        rd(ADDR_REASON, 32'h0000_001F);
        frame(F_NONE, F_NONE, sig, tdp, 8'h00, 1'b1);
        frame(14, F_NONE, sig, tdp, 8'h16, 1'b1);
        frame(F_NONE, F_NONE, sig, tdp, 8'h00, 1'b1);
        frame(F_NONE, F_NONE, ~sig, tdp, 8'h11, 1'b1);
        step(4'h1);
        pulse_tick();
        pulse_tick();
        step(4'h2);
        #1 check("sync lost", 32'h0000_0000, {31'h0, sync_lost});
        pulse_tick();
        step(4'h3);
        #1 check("sync lost", 32'h0000_0001, {31'h0, sync_lost});
        rd(ADDR_STATUS, 32'h0000_0007);
        wr(ADDR_STATUS, 32'h0000_0004);
        rd(ADDR_STATUS, 32'h0000_0003);
        wr(ADDR_CTRL, 32'h0000_001F);
        rd(ADDR_STATUS, 32'h0000_0002);
        rd(ADDR_CTRL, 32'h0000_0017);
        frame(F_NONE, F_NONE, $random(seed), 16'h03E8, 8'h00, 1'b1);
        @(posedge core_clk);
        bus_lost <= 1'b1;
        @(posedge core_clk);
        bus_lost <= 1'b0;
        rd(ADDR_STATUS, 32'h0000_0000);
        repeat (4) @(posedge core_clk);
        check("pending notes", 32'h0000_0000, 32'(exp_q.size()));
        end_of_test();
    end

endmodule : tb_top
